// ==== rtl/prox_calib_irq_regs.sv ====
// Calibration, averaging and interrupt-enable register slice
// Assumes a byte register port driven by the serial-bus front end,
// a converter that answers each request with one conv_done strobe,
// and saturation/threshold status levels produced elsewhere.
// Every output is a field of the state register, so no pin is combed.
//
// Overview of operation
// - Three-bit target field, resets to code two
// - Target scaled by four, low two bits ignored
// - Results masked by target before zero check
// - Nonzero averaging code averages consecutive windows
// - Codes 1..7 give windows 2..128, reset 0
// - Averaging updates result only at window end
// - Finished flag set on completion, write-one clears
// - Calibration interrupt only when its enable set
// - Bit 7 enables light saturation interrupt
// - Bit 6 enables proximity saturation interrupt
// - Bits 5 and 4 enable threshold interrupts
// - Bit 3 enables calibration interrupt
// - Start bit runs calibration; zero stops it
// - Electrical mode disables diodes, self-clears after
`timescale 1ns/1ps
module prox_calib_irq_regs (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic conv_done,
  input wire logic [15:0] conv_data,
  output logic conv_req,
  output logic [7:0] conv_offset,
  output logic diodes_off,
  output logic [7:0] proximity_offset,
  output logic [15:0] proximity_result,
  output logic result_update,
  input wire logic asat_stat,
  input wire logic psat_stat,
  input wire logic prox_stat,
  input wire logic als_stat,
  output logic int_out
);

  // ----------------------------------------------------------------
  // State of the slice
  // ----------------------------------------------------------------
  typedef struct packed {
    prox_calib_pkg::cal_state_e st;
    logic [2:0] bit_idx;
    logic [7:0] trial;
    logic [7:0] offset;
    logic start;
    logic elec;
    logic [2:0] tgt;
    logic rsv;
    logic [2:0] avg;
    logic cal_done;
    logic [4:0] ien;
    logic irq;
    logic req;
    logic diodes;
    logic [7:0] rdata;
    logic [15:0] result;
    logic upd;
    logic [7:0] ofs_out;
  } regs_s;

  regs_s q_r;
  regs_s q_nxt;

  logic avg_valid;
  logic [15:0] avg_data;
  logic norm_sample;

  // ----------------------------------------------------------------
  // Averager
  // ----------------------------------------------------------------
  // Only conversions outside a calibration feed the averager
  // One converter path serves both users; the sequencer state splits them
  assign norm_sample = conv_done && (q_r.st == prox_calib_pkg::CAL_IDLE);

  prox_window_avg u_avg (
    .mclk(mclk),
    .resetn(resetn),
    .sample_valid(norm_sample),
    .sample(conv_data),
    .avg_code(q_r.avg),
    .avg_valid(avg_valid),
    .avg_data(avg_data)
  );

  // ----------------------------------------------------------------
  // Register decode helpers
  // ----------------------------------------------------------------
  // Register image as read back by the host
  function automatic logic [7:0] read_mux(input regs_s s, input logic [7:0] a);
    logic [7:0] v;
    // Start from zero so unused bits always read back clear; the reserved bit reads back as stored
    v = 8'h00;
    case (a)
      prox_calib_pkg::ADDR_CAL_CTRL: begin
        v[prox_calib_pkg::CTRL_START_BIT] = s.start;
        v[prox_calib_pkg::CTRL_ELEC_BIT] = s.elec;
      end
      prox_calib_pkg::ADDR_CAL_CFG: begin
        v[prox_calib_pkg::CFG_TGT_LSB +: 3] = s.tgt;
        v[prox_calib_pkg::CFG_RSV_BIT] = s.rsv;
        v[prox_calib_pkg::CFG_AVG_LSB +: 3] = s.avg;
      end
      prox_calib_pkg::ADDR_CAL_STAT: begin
        v[prox_calib_pkg::STAT_DONE_BIT] = s.cal_done;
      end
      prox_calib_pkg::ADDR_INT_EN: begin
        v[prox_calib_pkg::IEN_CAL_BIT +: 5] = s.ien;
      end
      default: begin
        v = 8'h00; // Unmapped offsets read as zero
      end
    endcase
    return v;
  endfunction

  // Write strobe qualified by offset
  // A write to any other offset changes nothing in this slice
  function automatic logic hit(input logic wr, input logic [7:0] a,
                               input logic [7:0] target);
    return wr && (a == target);
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    // Scratch values, every one set before the state copy is touched
    logic wr_ctrl;
    logic wr_cfg;
    logic wr_stat;
    logic wr_ien;
    logic positive;
    logic finish;
    logic [7:0] bitmask;
    logic [4:0] flags;
    // One write strobe per mapped offset
    wr_ctrl = hit(reg_wr, reg_addr, prox_calib_pkg::ADDR_CAL_CTRL);
    wr_cfg = hit(reg_wr, reg_addr, prox_calib_pkg::ADDR_CAL_CFG);
    wr_stat = hit(reg_wr, reg_addr, prox_calib_pkg::ADDR_CAL_STAT);
    wr_ien = hit(reg_wr, reg_addr, prox_calib_pkg::ADDR_INT_EN);
    // Status causes in enable-bit order, bit 7 down to bit 3
    flags = {asat_stat, psat_stat, prox_stat, als_stat, q_r.cal_done};
    // Converter result counts as positive only above the masked target
    positive = |(conv_data & prox_calib_pkg::zero_mask_of(q_r.tgt));
    finish = 1'b0;
    bitmask = 8'h01 << q_r.bit_idx;
    q_nxt = q_r;
    q_nxt.req = 1'b0;
    q_nxt.upd = 1'b0;

    // --------------------------------------------------------------
    // Host writes
    // --------------------------------------------------------------
    // Configuration register: target, reserved bit and averaging
    // The reserved bit is stored so a read-back matches what was written
    if (wr_cfg) begin
      q_nxt.tgt = reg_wdata[prox_calib_pkg::CFG_TGT_LSB +: 3];
      q_nxt.rsv = reg_wdata[prox_calib_pkg::CFG_RSV_BIT];
      q_nxt.avg = reg_wdata[prox_calib_pkg::CFG_AVG_LSB +: 3];
    end

    // Interrupt enables, bits 7 down to 3
    if (wr_ien) begin
      q_nxt.ien = reg_wdata[prox_calib_pkg::IEN_CAL_BIT +: 5];
    end

    // Control register: electrical mode and start/stop
    if (wr_ctrl) begin
      q_nxt.elec = reg_wdata[prox_calib_pkg::CTRL_ELEC_BIT];
      q_nxt.start = reg_wdata[prox_calib_pkg::CTRL_START_BIT];
    end

    // --------------------------------------------------------------
    // Offset search
    // --------------------------------------------------------------
    // Successive approximation over the offset code, MSB first
    // Eight trials give the full code; the run length does not depend on data
    case (q_r.st)
      prox_calib_pkg::CAL_IDLE: begin
        // Start is only decoded here, so a second start cannot restart a run
        if (wr_ctrl && reg_wdata[prox_calib_pkg::CTRL_START_BIT]) begin
          q_nxt.st = prox_calib_pkg::CAL_TRY;
          q_nxt.bit_idx = prox_calib_pkg::OFS_MSB;
          q_nxt.trial = 8'h00;
          q_nxt.diodes = reg_wdata[prox_calib_pkg::CTRL_ELEC_BIT];
        end
      end
      prox_calib_pkg::CAL_TRY: begin
        // Offer the next trial bit and ask for one conversion
        q_nxt.trial = q_r.trial | bitmask;
        q_nxt.req = 1'b1;
        q_nxt.st = prox_calib_pkg::CAL_WAIT;
      end
      prox_calib_pkg::CAL_WAIT: begin
        // Data between answers is ignored; only the answer strobe counts
        if (conv_done) begin
          // Signal still above target means the offset is too small
          if (!positive) begin
            q_nxt.trial = q_r.trial & ~bitmask;
          end
          if (q_r.bit_idx == 3'h0) begin
            q_nxt.st = prox_calib_pkg::CAL_DONE;
          end else begin
            q_nxt.bit_idx = q_r.bit_idx - 3'h1;
            q_nxt.st = prox_calib_pkg::CAL_TRY;
          end
        end
      end
      prox_calib_pkg::CAL_DONE: begin
        // Result, flag and self-clearing bits all change on the same edge
        q_nxt.offset = q_r.trial;
        finish = 1'b1;
        q_nxt.st = prox_calib_pkg::CAL_IDLE;
        q_nxt.start = 1'b0;
        q_nxt.elec = 1'b0;
        q_nxt.diodes = 1'b0;
      end
      default: begin
        q_nxt.st = prox_calib_pkg::CAL_IDLE;
      end
    endcase

    // Writing zero to start abandons a search without a result
    if (wr_ctrl && !reg_wdata[prox_calib_pkg::CTRL_START_BIT]
        && (q_r.st != prox_calib_pkg::CAL_IDLE)) begin
      q_nxt.st = prox_calib_pkg::CAL_IDLE;
      q_nxt.diodes = 1'b0;
      finish = 1'b0;
      q_nxt.offset = q_r.offset;
      q_nxt.elec = reg_wdata[prox_calib_pkg::CTRL_ELEC_BIT];
    end

    // Front-end offset: trial code while searching, stored result otherwise
    // Taken from the next state so the pin is a flop yet keeps its timing
    if (q_nxt.st == prox_calib_pkg::CAL_IDLE) begin
      q_nxt.ofs_out = q_nxt.offset;
    end else begin
      q_nxt.ofs_out = q_nxt.trial;
    end

    // --------------------------------------------------------------
    // Status flag, result and interrupt
    // --------------------------------------------------------------
    // Finished flag: write-one clears, a completion in the same cycle wins
    q_nxt.cal_done = (q_r.cal_done
                      & ~(wr_stat & reg_wdata[prox_calib_pkg::STAT_DONE_BIT]))
                     | finish;

    // Proximity result follows the averager's window strobes
    if (avg_valid) begin
      q_nxt.result = avg_data;
      q_nxt.upd = 1'b1;
    end

    // Interrupt: any flag whose enable is set
    // Registered, so the pin trails its cause by one cycle
    q_nxt.irq = |(flags & q_r.ien);

    // Read data is captured on the read strobe and held
    // Reading the status byte leaves the flag alone; only a write-one clears
    if (reg_rd) begin
      q_nxt.rdata = read_mux(q_r, reg_addr);
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Asynchronous reset loads the power-up values, constants only
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q_r <= '0;
      q_r.st <= prox_calib_pkg::CAL_IDLE;
      q_r.tgt <= prox_calib_pkg::CFG_TGT_RST;
      // The reserved bit powers up set, as does bit 6 of its byte from target code two
      q_r.rsv <= prox_calib_pkg::CFG_RSV_RST;
      q_r.avg <= prox_calib_pkg::CFG_AVG_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  // Trial code drives the front end only while a search runs
  assign conv_offset = q_r.ofs_out;
  assign reg_rdata = q_r.rdata;
  assign conv_req = q_r.req;
  assign diodes_off = q_r.diodes;
  assign proximity_offset = q_r.offset;
  assign proximity_result = q_r.result;
  assign result_update = q_r.upd;
  assign int_out = q_r.irq;

endmodule // prox_calib_irq_regs

// ==== rtl/prox_calib_pkg.sv ====
// Constants, types and helpers shared by the calibration register slice
// Assumes a byte-wide register port and a 16-bit proximity converter
package prox_calib_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CAL_CTRL = 8'hd7;
  localparam logic [7:0] ADDR_CAL_CFG = 8'hd9;
  localparam logic [7:0] ADDR_CAL_STAT = 8'hdc;
  localparam logic [7:0] ADDR_INT_EN = 8'hdd;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ELEC_BIT = 5;
  localparam int CFG_TGT_LSB = 5;
  localparam int CFG_RSV_BIT = 4;
  localparam int CFG_AVG_LSB = 0;
  localparam int STAT_DONE_BIT = 0;
  localparam int IEN_ASAT_BIT = 7;
  localparam int IEN_PSAT_BIT = 6;
  localparam int IEN_PROX_BIT = 5;
  localparam int IEN_ALS_BIT = 4;
  localparam int IEN_CAL_BIT = 3;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int OFS_W = 8;
  localparam int SUM_W = 23;
  localparam logic [2:0] CFG_TGT_RST = 3'h2;
  localparam logic CFG_RSV_RST = 1'h1;
  localparam logic [2:0] CFG_AVG_RST = 3'h0;
  localparam logic [2:0] OFS_MSB = 3'h7;
  localparam logic [9:0] CMP_IGNORE = 10'h003;

  // ----------------------------------------------------------------
  // Calibration sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CAL_IDLE = 4'h1,
    CAL_TRY = 4'h2,
    CAL_WAIT = 4'h4,
    CAL_DONE = 4'h8
  } cal_state_e;

  // Ten-bit search target: (2^code - 1) scaled by four
  function automatic logic [9:0] target_of(input logic [2:0] code);
    logic [9:0] t;
    t = (10'h001 << code) - 10'h001;
    return t << 2;
  endfunction

  // Zero-detect mask: clears every bit at or below the target
  function automatic logic [15:0] zero_mask_of(input logic [2:0] code);
    return ~{6'h00, target_of(code) | CMP_IGNORE};
  endfunction

endpackage

// ==== rtl/prox_window_avg.sv ====
// Windowed averager for proximity samples
// Assumes samples arrive as single-cycle strobes in the mclk domain
`timescale 1ns/1ps
module prox_window_avg (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sample_valid,
  input wire logic [15:0] sample,
  input wire logic [2:0] avg_code,
  output logic avg_valid,
  output logic [15:0] avg_data
);

  typedef struct packed {
    logic [2:0] code;
    logic [7:0] cnt;
    logic [prox_calib_pkg::SUM_W-1:0] sum;
    logic valid;
    logic [15:0] data;
  } avg_s;

  avg_s q_r;
  avg_s q_nxt;

  // ----------------------------------------------------------------
  // Accumulate one window, then emit its mean
  // ----------------------------------------------------------------
  // Code 0 gives a window of one, so data passes straight through
  always_comb begin
    logic [prox_calib_pkg::SUM_W-1:0] acc;
    logic [7:0] last;
    acc = q_r.sum + {7'h00, sample};
    last = (8'h01 << q_r.code) - 8'h01;
    q_nxt = q_r;
    q_nxt.valid = 1'b0;
    if (avg_code != q_r.code) begin
      // A new window size restarts the window, partial sums are dropped
      q_nxt.code = avg_code;
      q_nxt.cnt = 8'h00;
      q_nxt.sum = '0;
    end else if (sample_valid) begin
      if (q_r.cnt == last) begin
        q_nxt.valid = 1'b1;
        q_nxt.data = 16'(acc >> q_r.code);
        q_nxt.cnt = 8'h00;
        q_nxt.sum = '0;
      end else begin
        q_nxt.cnt = q_r.cnt + 8'h01;
        q_nxt.sum = acc;
      end
    end
  end

  // State register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign avg_valid = q_r.valid;
  assign avg_data = q_r.data;

endmodule // prox_window_avg

// ==== verification/prox_calib_irq_regs_properties.sv ====
// Port-level checker for the calibration register slice
// Assumes it is bound into the top module, single mclk domain
`timescale 1ns/1ps
module prox_calib_irq_regs_properties (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic conv_done,
  input wire logic conv_req,
  input wire logic [7:0] proximity_offset,
  input wire logic [15:0] proximity_result,
  input wire logic result_update,
  input wire logic asat_stat,
  input wire logic psat_stat,
  input wire logic prox_stat,
  input wire logic als_stat,
  input wire logic int_out
);
  logic [7:0] ien_r;
  logic ext_cause;
  // Shadow of the enable byte, so no internal probes are needed
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ien_r <= 8'h00;
    end else if (reg_wr && reg_addr == prox_calib_pkg::ADDR_INT_EN) begin
      ien_r <= reg_wdata & 8'hf8;
    end
  end
  assign ext_cause = |({asat_stat, psat_stat, prox_stat, als_stat} & ien_r[7:4]);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_int_on;
    ext_cause |=> int_out;
  endproperty
  a_int_on: assert property (p_int_on) else $error("enabled flag gave no interrupt");
  property p_int_off;
    int_out |-> $past(ext_cause) || $past(ien_r[3]);
  endproperty
  a_int_off: assert property (p_int_off) else $error("interrupt without enabled cause");
  property p_ien_read;
    reg_rd && reg_addr == prox_calib_pkg::ADDR_INT_EN |=> reg_rdata == $past(ien_r);
  endproperty
  a_ien_read: assert property (p_ien_read) else $error("enable byte read wrong");
  property p_unmapped;
    reg_rd && !(reg_addr inside {8'hd7, 8'hd9, 8'hdc, 8'hdd}) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rdata_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_req_pulse;
    conv_req |=> !conv_req;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request longer than one cycle");
  property p_upd_cause;
    result_update |-> $past(conv_done, 2);
  endproperty
  a_upd_cause: assert property (p_upd_cause) else $error("result update without sample");
  property p_result_hold;
    !result_update |-> $stable(proximity_result);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result moved silently");
  property p_ofs_cause;
    $changed(proximity_offset) |-> $past(conv_done, 2) || $past(conv_done, 3);
  endproperty
  a_ofs_cause: assert property (p_ofs_cause) else $error("offset moved off completion");
endmodule // prox_calib_irq_regs_properties

bind prox_calib_irq_regs prox_calib_irq_regs_properties props (.mclk, .resetn, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .conv_done, .conv_req, .proximity_offset,
  .proximity_result, .result_update, .asat_stat, .psat_stat, .prox_stat, .als_stat, .int_out);

// ==== verification/conv_model.sv ====
// Converter front-end model answering conversion requests
// Assumes one-cycle conv_req pulses and a bench-driven sample kick
`timescale 1ns/1ps
module conv_model (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic conv_req,
  input wire logic [7:0] conv_offset,
  input wire logic [7:0] thr,
  input wire logic [15:0] big,
  input wire logic [15:0] low_val,
  input wire logic kick,
  input wire logic [15:0] kval,
  output logic conv_done,
  output logic [15:0] conv_data
);
  logic [2:0] cnt_r;
  // Answer four cycles after a request; data toggles between answers
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 3'h0;
      conv_done <= 1'b0;
      conv_data <= 16'h0000;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_req) cnt_r <= 3'h3;
      else if (cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
      // Positive reading while the trial offset is still too small
      if (cnt_r == 3'h1) begin
        conv_done <= 1'b1;
        conv_data <= (conv_offset < thr) ? big : low_val;
      end else if (kick) begin
        conv_done <= 1'b1;
        conv_data <= kval;
      end
    end
  end
endmodule // conv_model

// ==== verification/prox_calib_irq_regs_bench.sv ====
// Self-checking bench for the calibration register slice
// Assumes the converter model on the far side of the conversion port
`timescale 1ns/1ps
module prox_calib_irq_regs_bench;
  logic mclk, resetn, reg_wr, reg_rd, conv_done, conv_req, diodes_off, result_update, int_out;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, conv_offset, proximity_offset, thr;
  logic [15:0] conv_data, proximity_result, big, low_val, kval;
  logic [3:0] stat_v;
  logic kick;
  int fails, checks;
  prox_calib_irq_regs dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_done(conv_done),
    .conv_data(conv_data), .conv_req(conv_req), .conv_offset(conv_offset),
    .diodes_off(diodes_off), .proximity_offset(proximity_offset),
    .proximity_result(proximity_result), .result_update(result_update),
    .asat_stat(stat_v[3]), .psat_stat(stat_v[2]), .prox_stat(stat_v[1]),
    .als_stat(stat_v[0]), .int_out(int_out));
  conv_model model (.mclk(mclk), .resetn(resetn), .conv_req(conv_req), .conv_offset(conv_offset),
    .thr(thr), .big(big), .low_val(low_val), .kick(kick), .kval(kval), .conv_done(conv_done),
    .conv_data(conv_data));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle strobes, launched just after the edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge mclk) #1;
    reg_wr = 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge mclk) #1;
    reg_rd = 1'b0;
    @(posedge mclk) #1;
    chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, reg_rdata});
  endtask
  task automatic wrap_up();
    if (fails == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk(prox_calib_pkg::ADDR_CAL_CFG, 8'h50);
    rchk(prox_calib_pkg::ADDR_CAL_STAT, 8'h00);
    rchk(prox_calib_pkg::ADDR_INT_EN, 8'h00);
    rchk(8'hd8, 8'h00);
  endtask
  // Each status level is masked, then enabled by its own bit
  task automatic t_ien();
    for (int i = 0; i < 4; i++) begin
      wr(prox_calib_pkg::ADDR_INT_EN, 8'h00);
      stat_v = 4'h1 << i;
      repeat (3) @(posedge mclk);
      #1;
      chk("int_out masked", 16'h0000, {15'h0, int_out});
      wr(prox_calib_pkg::ADDR_INT_EN, 8'h10 << i);
      rchk(prox_calib_pkg::ADDR_INT_EN, 8'h10 << i);
      chk("int_out enabled", 16'h0001, {15'h0, int_out});
      stat_v = 4'h0;
      repeat (2) @(posedge mclk);
      #1;
      chk("int_out idle", 16'h0000, {15'h0, int_out});
    end
  endtask
  // The search must land on the largest offset still read as positive
  task automatic t_cal(input logic [2:0] code, input logic elec, input logic [7:0] t,
    input logic [15:0] b, input logic [15:0] s);
    thr = t;
    big = b;
    low_val = s;
    wr(prox_calib_pkg::ADDR_CAL_CFG, {code, 5'h10});
    wr(prox_calib_pkg::ADDR_INT_EN, 8'h08);
    wr(prox_calib_pkg::ADDR_CAL_CTRL, {2'h0, elec, 5'h01});
    repeat (2) @(posedge mclk);
    #1;
    chk("diodes_off run", {15'h0, elec}, {15'h0, diodes_off});
    for (int n = 0; n < 300 && int_out !== 1'b1; n++) begin
      @(posedge mclk) #1;
    end
    chk("int_out cal", 16'h0001, {15'h0, int_out});
    chk("proximity_offset", {8'h00, t - 8'h01}, {8'h00, proximity_offset});
    chk("diodes_off end", 16'h0000, {15'h0, diodes_off});
    rchk(prox_calib_pkg::ADDR_CAL_STAT, 8'h01);
    rchk(prox_calib_pkg::ADDR_CAL_CTRL, 8'h00);
    wr(prox_calib_pkg::ADDR_CAL_STAT, 8'h01);
    rchk(prox_calib_pkg::ADDR_CAL_STAT, 8'h00);
    chk("int_out clear", 16'h0000, {15'h0, int_out});
  endtask
  // Abort mid-search: no flag and the stored offset survives
  task automatic t_abort();
    wr(prox_calib_pkg::ADDR_CAL_CTRL, 8'h01);
    repeat (4) @(posedge mclk);
    wr(prox_calib_pkg::ADDR_CAL_CTRL, 8'h00);
    repeat (60) @(posedge mclk);
    rchk(prox_calib_pkg::ADDR_CAL_STAT, 8'h00);
    chk("offset kept", 16'h003f, {8'h00, proximity_offset});
    chk("int_out abort", 16'h0000, {15'h0, int_out});
  endtask
  // Every window code: one update per window, carrying the mean
  task automatic t_avg();
    int ups;
    for (int c = 0; c < 8; c++) begin
      wr(prox_calib_pkg::ADDR_CAL_CFG, {5'h12, c[2:0]});
      rchk(prox_calib_pkg::ADDR_CAL_CFG, {5'h12, c[2:0]});
      ups = 0;
      for (int i = 0; i < (1 << c); i++) begin
        kick = 1'b1;
        kval = 16'(2 * i);
        @(posedge mclk) #1;
        kick = 1'b0;
        repeat (4) begin
          @(posedge mclk) #1;
          if (result_update === 1'b1) ups++;
        end
      end
      chk("updates", 16'h0001, 16'(ups));
      chk("proximity_result", 16'((1 << c) - 1), proximity_result);
    end
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    #400000;
    fails++;
    wrap_up();
  end
  initial begin
    resetn = 1'b0;
    {reg_wr, reg_rd, kick} = 3'h0;
    {reg_addr, reg_wdata, thr} = 24'h0000_00;
    {big, low_val, kval} = 48'h0000_0000_0000;
    stat_v = 4'h0;
    fails = 0;
    checks = 0;
    repeat (10) @(posedge mclk);
    #1;
    resetn = 1'b1;
    t_reset();
    t_ien();
    t_cal(3'h2, 1'b0, 8'h5b, 16'h0010, 16'h000f);
    t_cal(3'h4, 1'b1, 8'h40, 16'h0040, 16'h003f);
    t_abort();
    t_avg();
    wrap_up();
  end
endmodule // prox_calib_irq_regs_bench
